// ==== design/dscc_status.sv ====
// dscc_status: status flags, save/restore and condition codes of the
// commercial-instruction unit.
// assumes control-store fields, bus data and datapath flags arrive
// on the same clock; processor init is a synchronous level.
// Operation
// - three digit-nonzero flags at status bits 7, 6, 5 for src1, src2, dst
// - nonzero flag takes inverse of low and high nibble zero indications
// - each nonzero flag loads only under its own field-four enable
// - nonzero flag holds until zero latched; clear or init clears all three
// - carry flag at bit 4 loads decimal carry when carry-load bit set
// - force-carry command from field four sets the carry flag
// - low-digit select picks low or high nibble carry via four-input selector
// - first sign at bit 8, second at bit 9, both from selected data sign
// - format select picks bus bit 15/7, 15, 6 or 0 as data sign
// - zoned 0011/0111 and packed 1100/1101 sign codes decode by one bit
// - each sign flag loads under own enable; init or positive sign clears
// - three odd-address flags set when loaded bus address bit 0 is set
// - save drives status bits 15:0 onto the bus under field-two decode
// - restore reloads all status latches from the bus under field-two decode
// - category lookup gives group select bit and three-bit category code
// - decimal N Z V C and sign from category, carry, nonzero and sign flags
// - sign: second for add/sub, xor for mul/div, zero compare, first otherwise
// - selectors pick decimal, string or bus codes into readable latch
// - string Z from word or low-byte zero indication
// - string C from word or low-byte carry, selectable, for move and compare; zero for the rest
// - string N is bit 7 or 15 for move/compare, bit 15 otherwise
// - string V only for move and compare, zero for the rest
`timescale 1ns/1ns

module dscc_status (
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  input wire logic PROCESSOR_INIT_I,
  input wire logic [4:0] AUX_CTRL_FIELD_FOUR_I,
  input wire logic [2:0] AUX_CTRL_FIELD_TWO_I,
  input wire logic CARRY_LOAD_FIELD_I,
  input wire logic [1:0] FORMAT_SELECT_I,
  input wire logic [1:0] CC_SOURCE_SELECT_I,
  input wire logic [7:0] INSTRUCTION_CODE_I,
  input wire logic [15:0] INTERNAL_BUS_I,
  input wire logic DEC_LOW_NIBBLE_ZERO_I,
  input wire logic DEC_HIGH_NIBBLE_ZERO_I,
  input wire logic DEC_LOW_CARRY_I,
  input wire logic DEC_HIGH_CARRY_I,
  input wire logic HIGH_BYTE_ZERO_I,
  input wire logic LOW_BYTE_ZERO_I,
  input wire logic WORD_CARRY_OUT_I,
  input wire logic BYTE_CARRY_OUT_I,
  input wire logic HIGH_BYTE_MSB_I,
  input wire logic LOW_BYTE_MSB_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WRITE_I,
  input wire logic REG_READ_I,
  output logic [31:0] REG_RDATA_O,
  output logic [15:0] INTERNAL_BUS_O,
  output logic INTERNAL_BUS_OE_N_O,
  output logic [15:0] STATUS_WORD_O,
  output logic [3:0] CONDITION_CODE_O,
  output logic RESULT_SIGN_O
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic f4_is(input logic [4:0] f, input dscc_pkg::dscc_f4_t code);
    f4_is = (f == code);
  endfunction : f4_is

  // category lookup: {group select, code}; group 1 is arithmetic
  function automatic logic [3:0] categorize(input logic [7:0] op);
    logic [3:0] c;
    c = 4'h0;
    case (op[3:0])
      4'h0: c = {1'b0, dscc_pkg::CAT_STR_MOVE};
      4'h1: c = {1'b0, dscc_pkg::CAT_STR_LOCATE};
      4'h2: c = {1'b1, dscc_pkg::CAT_ADD};
      4'h3: c = {1'b1, dscc_pkg::CAT_SUB};
      4'h4: c = {1'b1, dscc_pkg::CAT_DIV};
      4'h5: c = {1'b1, dscc_pkg::CAT_MUL};
      4'h6: c = {1'b1, dscc_pkg::CAT_CMP};
      4'h7: c = {1'b1, dscc_pkg::CAT_SHIFT};
      4'h8: c = {1'b1, dscc_pkg::CAT_CVT_FROM_LONG};
      4'h9: c = {1'b1, dscc_pkg::CAT_CVT_TO_LONG};
      default: c = {1'b0, dscc_pkg::CAT_STR_LOCATE};
    endcase
    categorize = c;
  endfunction : categorize

  logic [4:0] f4;
  logic save_sel;
  logic restore_sel;
  logic [15:0] status_q;
  logic [1:0] cfg_q;

  assign f4 = AUX_CTRL_FIELD_FOUR_I;
  assign save_sel = (AUX_CTRL_FIELD_TWO_I == dscc_pkg::F2_SAVE);
  assign restore_sel = (AUX_CTRL_FIELD_TWO_I == dscc_pkg::F2_RESTORE);

  // ----------------------------------------------------------------
  // digit-nonzero flags
  // ----------------------------------------------------------------
  logic [2:0] nz_q;
  logic [2:0] nz_load;
  logic nz_value;
  logic nz_clear;

  // set means the latched digit pair was nonzero
  assign nz_value = ~(DEC_LOW_NIBBLE_ZERO_I & DEC_HIGH_NIBBLE_ZERO_I);
  assign nz_clear = f4_is(f4, dscc_pkg::F4_NZ_CLEAR) | PROCESSOR_INIT_I;
  assign nz_load = {f4_is(f4, dscc_pkg::F4_NZ_SRC1), f4_is(f4, dscc_pkg::F4_NZ_SRC2),
                    f4_is(f4, dscc_pkg::F4_NZ_DST)};

  // nz_q[2]=src1 bit 7, [1]=src2 bit 6, [0]=dst bit 5
  // update at the edge closing the enabled cycle
  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      nz_q <= dscc_pkg::SW_RESET[dscc_pkg::SW_NZ_SRC1:dscc_pkg::SW_NZ_DST];
    end else if (nz_clear) begin
      nz_q <= 3'h0;
    end else if (restore_sel) begin
      nz_q <= INTERNAL_BUS_I[dscc_pkg::SW_NZ_SRC1:dscc_pkg::SW_NZ_DST];
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (nz_load[i]) begin
          nz_q[i] <= nz_value;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // carry/borrow flag
  // ----------------------------------------------------------------
  logic carry_q;
  logic [1:0] carry_pick;
  logic carry_next;
  logic carry_en;

  // four-input selector: high carry, low carry, bus, forced one
  always_comb begin
    carry_pick = 2'h0;
    if (restore_sel) begin
      carry_pick = 2'h2;
    end else if (f4_is(f4, dscc_pkg::F4_FORCE_CARRY)) begin
      carry_pick = 2'h3;
    end else if (f4_is(f4, dscc_pkg::F4_LOW_DIGIT)) begin
      carry_pick = 2'h1;
    end
    case (carry_pick)
      2'h0: carry_next = DEC_HIGH_CARRY_I;
      2'h1: carry_next = DEC_LOW_CARRY_I;
      2'h2: carry_next = INTERNAL_BUS_I[dscc_pkg::SW_CARRY];
      default: carry_next = 1'b1;
    endcase
  end

  // carry-load bit gates the decimal carry
  assign carry_en = CARRY_LOAD_FIELD_I | restore_sel | f4_is(f4, dscc_pkg::F4_FORCE_CARRY);

  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      carry_q <= dscc_pkg::SW_RESET[dscc_pkg::SW_CARRY];
    end else if (PROCESSOR_INIT_I) begin
      carry_q <= 1'b0;
    end else if (carry_en) begin
      carry_q <= carry_next;
    end
  end

  // ----------------------------------------------------------------
  // operand sign flags
  // ----------------------------------------------------------------
  logic sign1_q;
  logic sign2_q;
  logic data_sign;

  // zoned 0x3x/0x7x differ in bit 6, packed c/d in bit 0
  always_comb begin
    case (FORMAT_SELECT_I)
      dscc_pkg::FMT_CHAR: data_sign = INTERNAL_BUS_I[dscc_pkg::BUS_SIGN_HI] |
                                      INTERNAL_BUS_I[dscc_pkg::BUS_SIGN_LO];
      dscc_pkg::FMT_LONG: data_sign = INTERNAL_BUS_I[dscc_pkg::BUS_SIGN_HI];
      dscc_pkg::FMT_ZONED: data_sign = INTERNAL_BUS_I[dscc_pkg::BUS_ZONED_SIGN];
      dscc_pkg::FMT_PACKED: data_sign = INTERNAL_BUS_I[dscc_pkg::BUS_PACKED_SIGN];
      default: data_sign = 1'b0;
    endcase
  end

  // both flags share the selected data sign
  // own enable each; a positive sign loads as a clear
  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sign1_q <= dscc_pkg::SW_RESET[dscc_pkg::SW_SIGN1];
      sign2_q <= dscc_pkg::SW_RESET[dscc_pkg::SW_SIGN2];
    end else if (PROCESSOR_INIT_I) begin
      sign1_q <= 1'b0;
      sign2_q <= 1'b0;
    end else if (restore_sel) begin
      sign1_q <= INTERNAL_BUS_I[dscc_pkg::SW_SIGN1];
      sign2_q <= INTERNAL_BUS_I[dscc_pkg::SW_SIGN2];
    end else begin
      if (f4_is(f4, dscc_pkg::F4_SIGN1)) begin
        sign1_q <= data_sign;
      end
      if (f4_is(f4, dscc_pkg::F4_SIGN2)) begin
        sign2_q <= data_sign;
      end
    end
  end

  // ----------------------------------------------------------------
  // odd-address flags
  // ----------------------------------------------------------------
  logic [2:0] odd_q;
  logic [2:0] odd_load;

  assign odd_load = {f4_is(f4, dscc_pkg::F4_ODD_DST), f4_is(f4, dscc_pkg::F4_ODD_SRC2),
                     f4_is(f4, dscc_pkg::F4_ODD_SRC1)};

  // each flag follows bit 0 of the address it is loaded with
  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      odd_q <= dscc_pkg::SW_RESET[dscc_pkg::SW_ODD_DST:dscc_pkg::SW_ODD_SRC1];
    end else if (PROCESSOR_INIT_I) begin
      odd_q <= 3'h0;
    end else if (restore_sel) begin
      odd_q <= INTERNAL_BUS_I[dscc_pkg::SW_ODD_DST:dscc_pkg::SW_ODD_SRC1];
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (odd_load[i]) begin
          odd_q[i] <= INTERNAL_BUS_I[0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // decimal condition codes
  // ----------------------------------------------------------------
  logic [3:0] cat;
  logic s1;
  logic s2;
  logic sx;
  logic cb;
  logic nza;
  logic nzb;
  logic nzc;
  logic [3:0] dec_cc;
  logic dec_sign;

  assign cat = categorize(INSTRUCTION_CODE_I);
  assign s1 = sign1_q;
  assign s2 = sign2_q;
  assign sx = sign1_q ^ sign2_q;
  assign cb = carry_q;
  assign nza = nz_q[2];
  assign nzb = nz_q[1];
  assign nzc = nz_q[0];

  // lookup on category and flags; dec_cc is {N,Z,V,C}
  always_comb begin
    dec_cc = {1'b0, ~nza, cb | nzb, 1'b0};
    dec_sign = s1;
    case (cat[2:0])
      dscc_pkg::CAT_ADD, dscc_pkg::CAT_SUB: begin
        dec_cc[3] = s2 & nza;
        dec_sign = s2;
      end
      dscc_pkg::CAT_DIV: begin
        dec_cc = {sx & nza, ~nza, cb | nzb | ~nzc, ~nzc};
        dec_sign = sx;
      end
      dscc_pkg::CAT_MUL: begin
        dec_cc[3] = sx & nza;
        dec_sign = sx;
      end
      dscc_pkg::CAT_CMP: begin
        dec_cc[3] = (s1 & ~s2 & cb & nzb & nza) | (cb & ~s1) | (s1 & s2 & nza & ~cb);
        dec_cc[2] = (sx & ~nza & ~nzb & ~cb) | (sx & (nza | cb));
        dec_cc[1:0] = 2'h0;
        dec_sign = 1'b0;
      end
      dscc_pkg::CAT_CVT_TO_LONG: begin
        dec_cc[3] = s1 & nza;
        dec_cc[0] = s2 & nzc;
      end
      default: begin
        // shift and convert from long
        dec_cc[3] = s1 & nza;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // character-string condition codes
  // ----------------------------------------------------------------
  logic [3:0] str_cc;
  logic str_move;

  assign str_move = (cat[2:0] == dscc_pkg::CAT_STR_MOVE);

  always_comb begin
    str_cc[3] = str_move ? (HIGH_BYTE_MSB_I | LOW_BYTE_MSB_I) : HIGH_BYTE_MSB_I;
    // zero from byte or word zero indications
    str_cc[2] = (HIGH_BYTE_ZERO_I & LOW_BYTE_ZERO_I) |
                (str_move & cfg_q[dscc_pkg::CFG_BYTE_ZERO] & LOW_BYTE_ZERO_I);
    // overflow only for move and compare
    str_cc[1] = str_move & sx & (s2 ^ (HIGH_BYTE_MSB_I | LOW_BYTE_MSB_I));
    // carry from word or low byte, only for move and compare
    str_cc[0] = str_move & (cfg_q[dscc_pkg::CFG_BYTE_CARRY] ? BYTE_CARRY_OUT_I : WORD_CARRY_OUT_I);
  end

  // ----------------------------------------------------------------
  // condition-code latch
  // ----------------------------------------------------------------
  logic [3:0] cc_q;
  logic [3:0] cc_next;
  logic sign_out_q;
  logic [1:0] cc_pick;

  // restore forces the bus leg of the selectors
  assign cc_pick = restore_sel ? dscc_pkg::CCS_BUS : CC_SOURCE_SELECT_I;

  always_comb begin
    case (cc_pick)
      dscc_pkg::CCS_DECIMAL: cc_next = dec_cc;
      dscc_pkg::CCS_STRING: cc_next = str_cc;
      dscc_pkg::CCS_BUS: cc_next = INTERNAL_BUS_I[3:0];
      default: cc_next = cc_q;
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cc_q <= dscc_pkg::SW_RESET[3:0];
      sign_out_q <= 1'b0;
    end else if (PROCESSOR_INIT_I) begin
      cc_q <= 4'h0;
      sign_out_q <= 1'b0;
    end else begin
      cc_q <= cc_next;
      if (cc_pick == dscc_pkg::CCS_DECIMAL) begin
        sign_out_q <= dec_sign;
      end
    end
  end

  // ----------------------------------------------------------------
  // status word, save path and register port
  // ----------------------------------------------------------------
  assign status_q = {3'h0, odd_q, sign2_q, sign1_q, nz_q, carry_q, cc_q};

  // both bytes driven during a save cycle
  assign INTERNAL_BUS_O = status_q;
  assign INTERNAL_BUS_OE_N_O = ~save_sel;
  assign STATUS_WORD_O = status_q;
  assign CONDITION_CODE_O = cc_q;
  assign RESULT_SIGN_O = sign_out_q;

  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q <= dscc_pkg::CFG_RESET;
    end else if (REG_WRITE_I && REG_ADDR_I == dscc_pkg::REG_CFG) begin
      cfg_q <= REG_WDATA_I[1:0];
    end
  end

  // unmapped addresses and idle cycles read zero
  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      REG_RDATA_O <= 32'h0000_0000;
    end else if (REG_READ_I && REG_ADDR_I == dscc_pkg::REG_STATUS) begin
      REG_RDATA_O <= {16'h0000, status_q};
    end else if (REG_READ_I && REG_ADDR_I == dscc_pkg::REG_CFG) begin
      REG_RDATA_O <= {30'h0, cfg_q};
    end else begin
      REG_RDATA_O <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb_clk @(posedge CLOCK_I); endclocking
  default disable iff (!rst_n_q);

  sequence s_nz_load_src1;
    !PROCESSOR_INIT_I && f4 == dscc_pkg::F4_NZ_SRC1 && !restore_sel;
  endsequence

  a_nz_capture: assert property (s_nz_load_src1 |=> nz_q[2] == $past(nz_value))
    else $error("nonzero flag did not capture result");
  a_nz_hold: assert property (!PROCESSOR_INIT_I && !restore_sel && f4 == dscc_pkg::F4_NOP
    |=> $stable(nz_q))
    else $error("nonzero flags changed without enable");
  a_nz_clear: assert property (f4 == dscc_pkg::F4_NZ_CLEAR |=> nz_q == 3'h0)
    else $error("nonzero clear missed");
  a_carry_force: assert property (!PROCESSOR_INIT_I && f4 == dscc_pkg::F4_FORCE_CARRY
    && !restore_sel |=> carry_q)
    else $error("forced carry not set");
  a_carry_gate: assert property (!PROCESSOR_INIT_I && !carry_en |=> $stable(carry_q))
    else $error("carry changed without load");
  a_sign_packed: assert property (!PROCESSOR_INIT_I && !restore_sel && f4 == dscc_pkg::F4_SIGN1
    && FORMAT_SELECT_I == dscc_pkg::FMT_PACKED |=> sign1_q == $past(INTERNAL_BUS_I[0]))
    else $error("packed sign decode wrong");
  a_save_drive: assert property (save_sel |-> !INTERNAL_BUS_OE_N_O && INTERNAL_BUS_O == STATUS_WORD_O)
    else $error("status not driven on save");
  a_restore_all: assert property (restore_sel && !PROCESSOR_INIT_I && f4 != dscc_pkg::F4_NZ_CLEAR
    |=> STATUS_WORD_O[12:0] == $past(INTERNAL_BUS_I[12:0]))
    else $error("restore did not reload status");
  a_cmp_sign: assert property (!PROCESSOR_INIT_I && cc_pick == dscc_pkg::CCS_DECIMAL
    && cat[2:0] == dscc_pkg::CAT_CMP && cat[3] |=> !RESULT_SIGN_O)
    else $error("compare sign set");
  a_str_v_zero: assert property (!PROCESSOR_INIT_I && cc_pick == dscc_pkg::CCS_STRING
    && !str_move ##1 1 |-> !CONDITION_CODE_O[1])
    else $error("string overflow not zero");
  a_odd_follow: assert property (!PROCESSOR_INIT_I && !restore_sel && odd_load[0]
    |=> odd_q[0] == $past(INTERNAL_BUS_I[0]))
    else $error("odd flag wrong");

endmodule : dscc_status

// ==== design/dscc_pkg.sv ====
// dscc_pkg: constants for the decimal status and condition-code block
// assumes one 100 MHz clock; used as dscc_pkg::name, never imported
package dscc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAPTURE_LEAD_NS = 30;
  localparam int CAPTURE_LEAD_CYC = (CAPTURE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // status word bit positions
  // ----------------------------------------------------------------
  localparam int SW_CC_LSB = 0;
  localparam int SW_CARRY = 4;
  localparam int SW_NZ_DST = 5;
  localparam int SW_NZ_SRC2 = 6;
  localparam int SW_NZ_SRC1 = 7;
  localparam int SW_SIGN1 = 8;
  localparam int SW_SIGN2 = 9;
  localparam int SW_ODD_SRC1 = 10;
  localparam int SW_ODD_SRC2 = 11;
  localparam int SW_ODD_DST = 12;
  localparam logic [15:0] SW_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // data-sign source bits on the internal bus
  // ----------------------------------------------------------------
  localparam int BUS_SIGN_HI = 15;
  localparam int BUS_SIGN_LO = 7;
  localparam int BUS_ZONED_SIGN = 6;
  localparam int BUS_PACKED_SIGN = 0;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam int CFG_BYTE_CARRY = 0;
  localparam int CFG_BYTE_ZERO = 1;

  // ----------------------------------------------------------------
  // control-store field encodings
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    F4_NOP = 5'h00, F4_NZ_SRC1 = 5'h01, F4_NZ_SRC2 = 5'h02, F4_NZ_DST = 5'h03,
    F4_NZ_CLEAR = 5'h04, F4_FORCE_CARRY = 5'h05, F4_LOW_DIGIT = 5'h06,
    F4_SIGN1 = 5'h07, F4_SIGN2 = 5'h08, F4_ODD_SRC1 = 5'h09,
    F4_ODD_SRC2 = 5'h0a, F4_ODD_DST = 5'h0b
  } dscc_f4_t;

  typedef enum logic [2:0] {
    F2_NOP = 3'h0, F2_SAVE = 3'h1, F2_RESTORE = 3'h2
  } dscc_f2_t;

  typedef enum logic [1:0] {
    FMT_CHAR = 2'h0, FMT_LONG = 2'h1, FMT_ZONED = 2'h2, FMT_PACKED = 2'h3
  } dscc_fmt_t;

  typedef enum logic [1:0] {
    CCS_HOLD = 2'h0, CCS_DECIMAL = 2'h1, CCS_STRING = 2'h2, CCS_BUS = 2'h3
  } dscc_ccsel_t;

  // category codes (arithmetic group)
  localparam logic [2:0] CAT_CVT_TO_LONG = 3'h0;
  localparam logic [2:0] CAT_ADD = 3'h1;
  localparam logic [2:0] CAT_SUB = 3'h2;
  localparam logic [2:0] CAT_DIV = 3'h3;
  localparam logic [2:0] CAT_MUL = 3'h4;
  localparam logic [2:0] CAT_CMP = 3'h5;
  localparam logic [2:0] CAT_SHIFT = 3'h6;
  localparam logic [2:0] CAT_CVT_FROM_LONG = 3'h7;
  // category codes (string group)
  localparam logic [2:0] CAT_STR_LOCATE = 3'h0;
  localparam logic [2:0] CAT_STR_MOVE = 3'h1;

endpackage : dscc_pkg

// ==== sim/dscc_host_model.sv ====
// dscc_host_model: host side of the internal bus, pushes words and captures saved status words
// assumes the block drives the bus only while its active-low enable is low
`timescale 1ns/1ns
module dscc_host_model (
  input wire logic clk_i,
  input wire logic drive_i,
  input wire logic [15:0] word_i,
  input wire logic [15:0] dut_bus_i,
  input wire logic dut_oe_n_i,
  output logic [15:0] bus_o,
  output logic [15:0] saved_o
);
  logic [15:0] last_q = 16'hffff;
  // a released bus never shows a stale copy of the last word
  assign bus_o = !dut_oe_n_i ? dut_bus_i : (drive_i ? word_i : ~last_q);
  always_ff @(posedge clk_i) begin
    last_q <= bus_o;
    if (!dut_oe_n_i) begin
      saved_o <= dut_bus_i;
    end
  end
endmodule : dscc_host_model

// ==== sim/decimal_status_condition_codes_bench.sv ====
// decimal_status_condition_codes_bench: directed checks of flags, codes and registers
// assumes the host model owns the internal bus and a 100 MHz clock
`timescale 1ns/1ns
module decimal_status_condition_codes_bench;
  logic clk, rst_n, init, cld, dlz, dhz, dlc, dhc, hbz, lbz, wco, bco, hm, lm, wr, rd, drv, oe_n, rs;
  logic [4:0] f4;
  logic [2:0] f2;
  logic [1:0] fmt, ccs;
  logic [7:0] ic, addr;
  logic [15:0] word, bus, bo, sw, saved;
  logic [31:0] wd, rdata;
  logic [3:0] cc;
  logic [18:0] sg [7] = '{{2'h0, 16'h0080, 1'b1}, {2'h1, 16'h0080, 1'b0}, {2'h1, 16'h8000, 1'b1},
    {2'h2, 16'h0030, 1'b0}, {2'h2, 16'h0070, 1'b1}, {2'h3, 16'h001c, 1'b0}, {2'h3, 16'h001d, 1'b1}};
  int mismatches = 0;
  int checks_done = 0;

  dscc_status u_dut (.CLOCK_I(clk), .ARST_N_I(rst_n), .PROCESSOR_INIT_I(init), .AUX_CTRL_FIELD_FOUR_I(f4),
    .AUX_CTRL_FIELD_TWO_I(f2), .CARRY_LOAD_FIELD_I(cld), .FORMAT_SELECT_I(fmt), .CC_SOURCE_SELECT_I(ccs),
    .INSTRUCTION_CODE_I(ic), .INTERNAL_BUS_I(bus), .DEC_LOW_NIBBLE_ZERO_I(dlz), .DEC_HIGH_NIBBLE_ZERO_I(dhz),
    .DEC_LOW_CARRY_I(dlc), .DEC_HIGH_CARRY_I(dhc), .HIGH_BYTE_ZERO_I(hbz), .LOW_BYTE_ZERO_I(lbz),
    .WORD_CARRY_OUT_I(wco), .BYTE_CARRY_OUT_I(bco), .HIGH_BYTE_MSB_I(hm), .LOW_BYTE_MSB_I(lm),
    .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_WRITE_I(wr), .REG_READ_I(rd), .REG_RDATA_O(rdata),
    .INTERNAL_BUS_O(bo), .INTERNAL_BUS_OE_N_O(oe_n), .STATUS_WORD_O(sw), .CONDITION_CODE_O(cc),
    .RESULT_SIGN_O(rs));
  dscc_host_model u_host (.clk_i(clk), .drive_i(drv), .word_i(word), .dut_bus_i(bo), .dut_oe_n_i(oe_n),
    .bus_o(bus), .saved_o(saved));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // one control word for a cycle; settled outputs are read 1 ns after the capture edge
  task automatic cmd(input logic [4:0] c4, input logic [15:0] w = 16'h0000, input logic [2:0] c2 = 3'h0);
    @(posedge clk);
    {f4, f2, drv, word} <= {c4, c2, 1'b1, w};
    @(posedge clk);
    {f4, f2, drv} <= '0;
    #1;
  endtask : cmd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(rdata, e);
  endtask : rd_chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {addr, wd, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic print_verdict();
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // hang guard: the whole run needs well under this many cycles
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  initial begin
    {rst_n, init, cld, dlz, dhz, dlc, dhc, hbz, lbz, wco, bco, hm, lm, wr, rd, drv} = '0;
    {f4, f2, fmt, ccs, ic, addr, word, wd} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    cmd(dscc_pkg::F4_NZ_SRC1);
    cmp(sw[7:5], 3'b100);
    {dlz, dhz} <= 2'b10;
    cmd(dscc_pkg::F4_NZ_SRC2);
    cmp(sw[7:5], 3'b110);
    {dlz, dhz} <= 2'b11;
    cmd(dscc_pkg::F4_NZ_DST);
    cmd(dscc_pkg::F4_NZ_SRC2);
    cmp(sw[7:5], 3'b100);
    {dlz, dhz} <= 2'b00;
    cmd(dscc_pkg::F4_NZ_DST);
    cmp(sw[7:5], 3'b101);
    cmd(dscc_pkg::F4_NZ_CLEAR);
    cmp(sw[7:5], 3'b000);
    {cld, dlc, dhc} <= 3'b101;
    cmd(dscc_pkg::F4_NOP);
    cmp(sw[4], 1'b1);
    {cld, dhc} <= 2'b00;
    cmd(dscc_pkg::F4_NOP);
    cmp(sw[4], 1'b1);
    {cld, dhc} <= 2'b11;
    cmd(dscc_pkg::F4_LOW_DIGIT);
    cld <= 1'b0;
    cmp(sw[4], 1'b0);
    cmd(dscc_pkg::F4_FORCE_CARRY);
    cmp(sw[4], 1'b1);
    foreach (sg[i]) begin
      fmt <= sg[i][18:17];
      cmd(dscc_pkg::F4_SIGN1, sg[i][16:1]);
      cmp(sw[9:8], {1'b0, sg[i][0]});
    end
    cmd(dscc_pkg::F4_SIGN2, 16'h001d);
    cmp(sw[9:8], 2'b11);
    cmd(dscc_pkg::F4_SIGN2, 16'h001c);
    cmd(dscc_pkg::F4_ODD_SRC1, 16'h0001);
    cmd(dscc_pkg::F4_ODD_SRC2, 16'h0002);
    cmd(dscc_pkg::F4_ODD_DST, 16'h0003);
    cmd(dscc_pkg::F4_NZ_SRC1);
    cmp(sw, 16'h1590);
    cmd(dscc_pkg::F4_NOP, 16'h0000, dscc_pkg::F2_SAVE);
    cmp(saved, 16'h1590);
    cmp(oe_n, 1'b1);
    rd_chk(dscc_pkg::REG_STATUS, 32'h0000_1590);
    wr_reg(dscc_pkg::REG_STATUS, 32'hffff_ffff);
    rd_chk(dscc_pkg::REG_STATUS, 32'h0000_1590);
    rd_chk(8'h08, 32'h0000_0000);
    ccs <= dscc_pkg::CCS_DECIMAL;
    for (int k = 2; k < 10; k++) begin
      ic <= k[7:0];
      cmd(dscc_pkg::F4_NOP);
      cmp(cc[3:2], (k == 6) ? 2'b01 : {k inside {4, 5, 7, 8, 9}, 1'b0});
      cmp(cc[1:0], {k != 6, k == 4});
      cmp(rs, k inside {4, 5, 7, 8, 9});
    end
    ccs <= dscc_pkg::CCS_STRING;
    {ic, lm, hm, lbz, hbz, wco, bco} <= {8'h00, 6'b101010};
    wr_reg(dscc_pkg::REG_CFG, 32'h0000_0002);
    cmd(dscc_pkg::F4_NOP);
    cmp(cc, 4'hf);
    wr_reg(dscc_pkg::REG_CFG, 32'h0000_0003);
    cmd(dscc_pkg::F4_NOP);
    cmp(cc, 4'he);
    rd_chk(dscc_pkg::REG_CFG, 32'h0000_0003);
    ic <= 8'h01;
    cmd(dscc_pkg::F4_NOP);
    cmp({cc[3], cc[1]}, 2'b00);
    ccs <= dscc_pkg::CCS_BUS;
    cmd(dscc_pkg::F4_NOP, 16'h0005);
    ccs <= dscc_pkg::CCS_HOLD;
    cmd(dscc_pkg::F4_NOP);
    cmp(cc, 4'h5);
    cmd(dscc_pkg::F4_NOP, 16'hea6b, dscc_pkg::F2_RESTORE);
    cmp(sw, 16'h0a6b);
    init <= 1'b1;
    cmd(dscc_pkg::F4_NZ_SRC1);
    init <= 1'b0;
    cmp({rs, cc, sw}, 21'h000000);
    print_verdict();
  end
endmodule : decimal_status_condition_codes_bench
